// ==== rtl/spdc_pkg.sv ====
// ============================================================
// Sleep power-down control: shared constants
package spdc_pkg;

    // ========================================================
    // Clock and timing
    localparam int CLK_PERIOD_NS = 50;       // 20 MHz system clock
    localparam int OSC_PERIOD_NS = 50;       // Crystal period, same clock here
    localparam int OST_TOSC      = 1024;     // Oscillator start-up, in periods
    localparam int OST_CYCLES    =
        (OST_TOSC * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REG_STAB_NS   = 5000;     // Regulator recovery time
    localparam int REG_CYCLES    =
        (REG_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W         = 11;

    // ========================================================
    // APB register byte offsets
    localparam logic [7:0] OFF_REGCTL = 8'h00;   // regulator_control
    localparam logic [7:0] OFF_STATUS = 8'h04;   // Flags and live state
    localparam logic [7:0] OFF_CONFIG = 8'h08;   // Clock and sleep options

    // ========================================================
    // Field positions
    localparam int REGCTL_RSVD_BIT = 0;          // Reserved, reads one
    localparam int REGCTL_LPS_BIT  = 1;          // regulator_power_mode_sel
    localparam int ST_PD_BIT       = 0;          // power_down_flag
    localparam int ST_TO_BIT       = 1;          // timeout_flag
    localparam int ST_SLEEP_BIT    = 2;
    localparam int ST_LPWR_BIT     = 3;
    localparam int ST_WAKING_BIT   = 4;
    localparam int CFG_XTAL_BIT    = 0;          // Crystal oscillator mode
    localparam int CFG_TWOSPD_BIT  = 1;          // Two-speed start-up
    localparam int CFG_WDTSLP_BIT  = 2;          // Watchdog runs in sleep
    localparam int CFG_ADCRC_BIT   = 3;          // ADC on its own RC clock
    localparam int CFG_T1SRC_LSB   = 4;          // Timer1 source, 2 bits
    localparam int CFG_W           = 6;

    // ========================================================
    // Reset values
    localparam logic       PD_RST     = 1'b1;
    localparam logic       TO_RST     = 1'b1;
    localparam logic       LPS_RST    = 1'b0;
    localparam logic [5:0] CONFIG_RST = 6'h00;

    // Timer1 clock sources; only the system clock stops in sleep
    localparam logic [1:0] T1SRC_SYS  = 2'h0;

    // ========================================================
    // Controller states
    typedef enum logic [1:0] {
        ST_RUN      = 2'h0,
        ST_SLEEP    = 2'h1,
        ST_WAIT_OSC = 2'h2,
        ST_WAIT_REG = 2'h3
    } spdc_state_e;

endpackage : spdc_pkg

// ==== rtl/spdc_top.sv ====
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/100ps
// Operation
// - Sleep is entered only when the core executes the Sleep instruction.
// - On entry clear the watchdog; it keeps running if enabled for sleep.
// - On entry clear the power-down flag and set the timeout flag.
// - CPU clock stops in sleep; the low-frequency oscillator keeps running.
// - Timer1 keeps running in sleep unless clocked from the system clock.
// - The converter keeps working in sleep on its dedicated RC clock.
// - All I/O pins hold their drive state throughout sleep.
// - Reset sources other than the watchdog act the same asleep or awake.
// - Wake on pin reset, brown-out, power-on, watchdog or enabled interrupt.
// - Pin, brown-out and power-on resets reset; the others resume execution.
// - The next instruction is prefetched while Sleep executes.
// - Interrupts wake only when individually enabled, whatever the global enable.
// - With global enable, run the prefetched instruction then the vector.
// - The watchdog is cleared on every wake, whatever the source.
// - Interrupt pending before Sleep makes it a no-op; flags and watchdog kept.
// - Interrupt during or after Sleep: enter, then wake at once.
// - Crystal wake waits 1024 oscillator periods unless two-speed start-up.
// - Software reads the power-down flag to see whether Sleep really ran.
// - Low-power mode bit puts regulator and reference in low power.
// - Low-power sleep adds a stabilisation delay on wake; normal does not.
// - Unregulated variants always sleep lowest-power with no added delay.
// - Mode select is bit 1, resets to zero; bit 0 reads one.
module spdc_top #(
    parameter int N_INT     = 8,
    parameter bit REGULATED = 1'b1
) (
    input  wire logic                     clk,
    input  wire logic                     resetn,
    // APB slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // Core and event sources
    input  wire logic                     sleep_exec,
    input  wire logic [N_INT-1:0]         int_flags,
    input  wire logic [N_INT-1:0]         int_enables,
    input  wire logic                     global_int_enable,
    input  wire logic                     external_reset_pin,
    input  wire logic                     brownout_reset,
    input  wire logic                     por_reset,
    input  wire logic                     watchdog_timeout,
    // Control outputs
    output logic                          cpu_clk_en,
    output logic                          low_freq_internal_osc_en,
    output logic                          timer1_clk_en,
    output logic                          adc_clk_en,
    output logic                          io_hold,
    output logic                          watchdog_counter_clear,
    output logic                          watchdog_counter_run,
    output logic                          prefetch_next,
    output logic                          resume_exec,
    output logic                          vector_call,
    output logic                          device_reset_req,
    output logic                          regulator_low_power,
    output logic                          sleep_active,
    output logic                          power_down_flag,
    output logic                          timeout_flag
);
    import spdc_pkg::*;

    // ========================================================
    // Parameter checks
    initial begin
        if (N_INT < 1 || N_INT > 32)
            $error("spdc_top: N_INT must be 1 to 32");
        if (OST_CYCLES >= (1 << CNT_W) || REG_CYCLES >= (1 << CNT_W))
            $error("spdc_top: delay counts exceed counter width");
    end

    // ========================================================
    // State
    typedef struct packed {
        spdc_state_e        st;
        logic [CNT_W-1:0]   cnt;
        logic               reg_pending;   // Regulator wait still owed
        logic               wake_gie;      // Global enable seen at wake
        logic               lps;           // regulator_power_mode_sel
        logic [CFG_W-1:0]   cfg;
        logic               pd;
        logic               to;
        logic               cpu_en;
        logic               t1_en;
        logic               adc_en;
        logic               hold;
        logic               wdt_clr;
        logic               wdt_run;
        logic               prefetch;
        logic               resume;
        logic               vec;
        logic               rst_req;
        logic               reg_lp;
        logic               sleeping;
        logic [31:0]        rdata;
        logic               ready;
        logic               slverr;
        logic [CNT_W-1:0]   osc_len;       // Cycles spent in start-up wait
    } spdc_state_s;

    spdc_state_s s_q;
    spdc_state_s s_d;

    // Interrupt wake request, global enable ignored
    function automatic logic int_wake(input logic [N_INT-1:0] f,
                                      input logic [N_INT-1:0] e);
        return |(f & e);
    endfunction : int_wake

    // Oscillator start-up cycles owed before resuming, zero when none owed
    function automatic logic [CNT_W-1:0] osc_wait(input logic [CFG_W-1:0] c);
        if (c[CFG_XTAL_BIT] && !c[CFG_TWOSPD_BIT])
            return CNT_W'(OST_CYCLES);
        return '0;
    endfunction : osc_wait

    logic lp_eff;
    logic reset_src;
    logic cont_wake;
    logic apb_acc;
    logic apb_wr;
    assign lp_eff    = REGULATED ? s_q.lps : 1'b0;
    assign reset_src = external_reset_pin | brownout_reset | por_reset;
    assign cont_wake = watchdog_timeout | int_wake(int_flags, int_enables);
    assign apb_acc   = psel & penable & s_q.ready;
    assign apb_wr    = apb_acc & pwrite;

    // ========================================================
    // Next-state logic
    always_comb begin
        s_d          = s_q;
        s_d.wdt_clr  = 1'b0;
        s_d.prefetch = 1'b0;
        s_d.resume   = 1'b0;
        s_d.vec      = 1'b0;
        s_d.osc_len  = (s_q.st == ST_WAIT_OSC) ? s_q.osc_len + CNT_W'(1) : '0; // Checker only
        // Resets pass through in every state; the watchdog only in run
        s_d.rst_req  = reset_src | (watchdog_timeout & (s_q.st == ST_RUN));

        // APB register writes; hardware flag updates below take priority
        if (apb_wr) begin
            case (paddr)
                OFF_REGCTL: begin
                    if (REGULATED)
                        s_d.lps = pwdata[REGCTL_LPS_BIT];
                end
                OFF_STATUS: begin
                    s_d.pd = pwdata[ST_PD_BIT];
                    s_d.to = pwdata[ST_TO_BIT];
                end
                OFF_CONFIG: s_d.cfg = pwdata[CFG_W-1:0];
                default: ;
            endcase
        end

        case (s_q.st)
            ST_RUN: begin
                if (sleep_exec && !reset_src) begin
                    s_d.prefetch = 1'b1;
                    // Pending enabled interrupt turns Sleep into a no-op
                    if (!int_wake(int_flags, int_enables)) begin
                        s_d.st       = ST_SLEEP;
                        s_d.wdt_clr  = 1'b1;
                        s_d.wdt_run  = s_q.cfg[CFG_WDTSLP_BIT];
                        s_d.pd       = 1'b0;
                        s_d.to       = 1'b1;
                        s_d.cpu_en   = 1'b0;
                        s_d.hold     = 1'b1;
                        s_d.sleeping = 1'b1;
                        s_d.reg_lp   = REGULATED ? s_q.lps : 1'b1;
                        s_d.t1_en    = s_q.cfg[CFG_T1SRC_LSB +: 2] != T1SRC_SYS;
                        s_d.adc_en   = s_q.cfg[CFG_ADCRC_BIT];
                    end
                end
            end
            ST_SLEEP: begin
                if (reset_src) begin
                    // Reset class wake: the reset logic takes over
                    s_d.st       = ST_RUN;
                    s_d.wdt_clr  = 1'b1;
                    s_d.cpu_en   = 1'b1;
                    s_d.hold     = 1'b0;
                    s_d.sleeping = 1'b0;
                    s_d.reg_lp   = 1'b0;
                    s_d.t1_en    = 1'b1;
                    s_d.adc_en   = 1'b1;
                end else if (cont_wake) begin
                    s_d.wdt_clr     = 1'b1;
                    s_d.wake_gie    = global_int_enable;
                    s_d.reg_lp      = 1'b0;
                    s_d.reg_pending = lp_eff;
                    if (osc_wait(s_q.cfg) != '0) begin
                        s_d.st  = ST_WAIT_OSC;
                        s_d.cnt = osc_wait(s_q.cfg) - CNT_W'(1);
                    end else if (lp_eff) begin
                        s_d.st  = ST_WAIT_REG;
                        s_d.cnt = CNT_W'(REG_CYCLES - 1);
                    end else begin
                        // Normal sleep resumes on the next edge
                        s_d.st       = ST_RUN;
                        s_d.resume   = 1'b1;
                        s_d.vec      = global_int_enable;
                        s_d.cpu_en   = 1'b1;
                        s_d.hold     = 1'b0;
                        s_d.sleeping = 1'b0;
                        s_d.t1_en    = 1'b1;
                        s_d.adc_en   = 1'b1;
                    end
                end
            end
            ST_WAIT_OSC, ST_WAIT_REG: begin
                if (reset_src) begin
                    s_d.st       = ST_RUN;
                    s_d.cpu_en   = 1'b1;
                    s_d.hold     = 1'b0;
                    s_d.sleeping = 1'b0;
                    s_d.t1_en    = 1'b1;
                    s_d.adc_en   = 1'b1;
                end else if (s_q.cnt != '0) begin
                    s_d.cnt = s_q.cnt - CNT_W'(1);
                end else if (s_q.st == ST_WAIT_OSC && s_q.reg_pending) begin
                    // Both delays owed: regulator follows oscillator
                    s_d.st  = ST_WAIT_REG;
                    s_d.cnt = CNT_W'(REG_CYCLES - 1);
                end else begin
                    s_d.st          = ST_RUN;
                    s_d.reg_pending = 1'b0;
                    s_d.resume      = 1'b1;
                    s_d.vec         = s_q.wake_gie;
                    s_d.cpu_en      = 1'b1;
                    s_d.hold        = 1'b0;
                    s_d.sleeping    = 1'b0;
                    s_d.t1_en       = 1'b1;
                    s_d.adc_en      = 1'b1;
                end
            end
            default: s_d.st = ST_RUN;
        endcase

        // APB answer: one wait state, then data and ready together
        s_d.ready  = psel & penable & !s_q.ready;
        s_d.slverr = 1'b0;
        s_d.rdata  = '0;
        if (psel && penable && !s_q.ready) begin
            case (paddr)
                OFF_REGCTL: begin
                    s_d.rdata[REGCTL_RSVD_BIT] = 1'b1;
                    s_d.rdata[REGCTL_LPS_BIT]  = lp_eff;
                end
                OFF_STATUS: begin
                    s_d.rdata[ST_PD_BIT]     = s_q.pd;
                    s_d.rdata[ST_TO_BIT]     = s_q.to;
                    s_d.rdata[ST_SLEEP_BIT]  = s_q.sleeping;
                    s_d.rdata[ST_LPWR_BIT]   = s_q.reg_lp;
                    s_d.rdata[ST_WAKING_BIT] = s_q.st[1];
                end
                OFF_CONFIG: s_d.rdata[CFG_W-1:0] = s_q.cfg;
                default:    s_d.slverr = 1'b1;
            endcase
        end
    end

    // ========================================================
    // State register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q             <= '0;
            s_q.st          <= ST_RUN;
            s_q.lps         <= LPS_RST;
            s_q.cfg         <= CONFIG_RST;
            s_q.pd          <= PD_RST;
            s_q.to          <= TO_RST;
            s_q.cpu_en      <= 1'b1;
            s_q.t1_en       <= 1'b1;
            s_q.adc_en      <= 1'b1;
            s_q.wdt_run     <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ========================================================
    // Outputs, all but the oscillator enable straight from the state register
    assign prdata                   = s_q.rdata;
    assign pready                   = s_q.ready;
    assign pslverr                  = s_q.slverr;
    assign cpu_clk_en               = s_q.cpu_en;
    assign low_freq_internal_osc_en = 1'b1;   // never gated by this block
    assign timer1_clk_en            = s_q.t1_en;
    assign adc_clk_en               = s_q.adc_en;
    assign io_hold                  = s_q.hold;
    assign watchdog_counter_clear   = s_q.wdt_clr;
    assign watchdog_counter_run     = s_q.wdt_run;
    assign prefetch_next            = s_q.prefetch;
    assign resume_exec              = s_q.resume;
    assign vector_call              = s_q.vec;
    assign device_reset_req         = s_q.rst_req;
    assign regulator_low_power      = s_q.reg_lp;
    assign sleep_active             = s_q.sleeping;
    assign power_down_flag          = s_q.pd;
    assign timeout_flag             = s_q.to;

    // ========================================================
    // Assertions
    sequence s_sleep_cont;
        s_q.st == ST_SLEEP && !reset_src && cont_wake;
    endsequence

    sequence s_fast_wake;
        s_sleep_cont and (osc_wait(s_q.cfg) == '0 && !lp_eff);
    endsequence

    property p_entry_cause;
        @(posedge clk) disable iff (!resetn)
        $rose(s_q.sleeping) |-> $past(sleep_exec) && !$past(int_wake(int_flags, int_enables));
    endproperty
    a_entry_cause: assert property (p_entry_cause) else $error("sleep without instruction");

    property p_entry_flags;
        @(posedge clk) disable iff (!resetn)
        $rose(s_q.sleeping) |-> !s_q.pd && s_q.to && s_q.wdt_clr && s_q.prefetch;
    endproperty
    a_entry_flags: assert property (p_entry_flags) else $error("entry effects wrong");

    property p_sleep_clocks;
        @(posedge clk) disable iff (!resetn)
        s_q.st == ST_SLEEP |-> !cpu_clk_en && io_hold && low_freq_internal_osc_en;
    endproperty
    a_sleep_clocks: assert property (p_sleep_clocks) else $error("clock or pins in sleep");

    property p_nop_sleep;
        @(posedge clk) disable iff (!resetn)
        (s_q.st == ST_RUN && sleep_exec && !reset_src && !apb_wr
            && int_wake(int_flags, int_enables))
        |=> !s_q.sleeping && s_q.pd == $past(s_q.pd) && s_q.to == $past(s_q.to)
            && !s_q.wdt_clr && s_q.prefetch;
    endproperty
    a_nop_sleep: assert property (p_nop_sleep) else $error("no-op sleep changed state");

    property p_stay_asleep;
        @(posedge clk) disable iff (!resetn)
        (s_q.st == ST_SLEEP && !reset_src && !cont_wake) |=> s_q.st == ST_SLEEP;
    endproperty
    a_stay_asleep: assert property (p_stay_asleep) else $error("woke without event");

    property p_wake_clear;
        @(posedge clk) disable iff (!resetn)
        (s_q.st == ST_SLEEP && (reset_src || cont_wake)) |=> watchdog_counter_clear;
    endproperty
    a_wake_clear: assert property (p_wake_clear) else $error("watchdog not cleared on wake");

    property p_reset_wake;
        @(posedge clk) disable iff (!resetn)
        (s_q.st == ST_SLEEP && reset_src) |=> device_reset_req && !resume_exec;
    endproperty
    a_reset_wake: assert property (p_reset_wake) else $error("reset wake resumed");

    property p_fast_wake;
        @(posedge clk) disable iff (!resetn)
        s_fast_wake |=> resume_exec && cpu_clk_en && vector_call == $past(global_int_enable);
    endproperty
    a_fast_wake: assert property (p_fast_wake) else $error("normal wake delayed");

    property p_osc_wait;
        @(posedge clk) disable iff (!resetn)
        (s_sleep_cont and osc_wait(s_q.cfg) != '0) |=> (!cpu_clk_en && !resume_exec) [*8];
    endproperty
    a_osc_wait: assert property (p_osc_wait) else $error("start-up wait wrong");

    // Wait too long for a delay range: its own cycle count must end at the full span
    property p_osc_len;
        @(posedge clk) disable iff (!resetn)
        ((s_q.st == ST_WAIT_OSC) ? (s_q.osc_len < CNT_W'(OST_CYCLES))
            : (s_q.osc_len == '0 || s_q.osc_len == CNT_W'(OST_CYCLES) || device_reset_req));
    endproperty
    a_osc_len: assert property (p_osc_len) else $error("start-up wait length wrong");

    property p_lp_wait;
        @(posedge clk) disable iff (!resetn)
        (s_sleep_cont and (osc_wait(s_q.cfg) == '0 && lp_eff))
        |=> (!resume_exec) [*8] ##[1:200] resume_exec;
    endproperty
    a_lp_wait: assert property (p_lp_wait) else $error("low-power wake not delayed");

    property p_t1_run;
        @(posedge clk) disable iff (!resetn)
        $rose(s_q.sleeping) |-> timer1_clk_en == ($past(s_q.cfg[CFG_T1SRC_LSB +: 2]) != T1SRC_SYS)
            && adc_clk_en == $past(s_q.cfg[CFG_ADCRC_BIT]);
    endproperty
    a_t1_run: assert property (p_t1_run) else $error("peripheral clock gating wrong");

endmodule : spdc_top

// ==== test/spdc_core_model.sv ====
`timescale 1ns/100ps
// ============================================================
// Core, interrupt sources and reset sources facing the controller
module spdc_core_model #(
    parameter int N_INT = 8
) (
    input  wire logic             clk,
    output logic                  sleep_exec,
    output logic [N_INT-1:0]      int_flags,
    output logic [N_INT-1:0]      int_enables,
    output logic                  global_int_enable,
    output logic                  external_reset_pin,
    output logic                  brownout_reset,
    output logic                  por_reset,
    output logic                  watchdog_timeout
);
    // Quiet at time zero so nothing wakes or resets by accident
    initial begin
        {sleep_exec, int_flags, int_enables, global_int_enable} = '0;
        {watchdog_timeout, por_reset, brownout_reset, external_reset_pin} = 4'h0;
    end

    // Sleep instruction issue: exactly one cycle, as the core executes it once
    task automatic do_sleep();
        @(posedge clk);
        sleep_exec <= 1'h1;
        @(posedge clk);
        sleep_exec <= 1'h0;
    endtask : do_sleep

    // Interrupt levels stay until the core clears them
    task automatic set_int(input logic [N_INT-1:0] f, input logic [N_INT-1:0] e,
                           input logic g);
        @(posedge clk);
        int_flags <= f;
        int_enables <= e;
        global_int_enable <= g;
    endtask : set_int

    // One-cycle event: 0 pin, 1 brown-out, 2 power-on, 3 watchdog
    task automatic pulse_src(input int k);
        @(posedge clk);
        {watchdog_timeout, por_reset, brownout_reset, external_reset_pin} <= 4'h1 << k;
        @(posedge clk);
        {watchdog_timeout, por_reset, brownout_reset, external_reset_pin} <= 4'h0;
    endtask : pulse_src
endmodule : spdc_core_model

// ==== test/tb.sv ====
`timescale 1ns/100ps
// ============================================================
// Self-checking bench for the sleep controller
module tb;
    import spdc_pkg::*;
    logic clk, resetn, psel, penable, pwrite, pready, pslverr, sleep_exec;
    logic [7:0] paddr, int_flags, int_enables;
    logic [31:0] pwdata, prdata;
    logic global_int_enable, external_reset_pin, brownout_reset, por_reset, watchdog_timeout;
    logic cpu_clk_en, low_freq_internal_osc_en, timer1_clk_en, adc_clk_en, io_hold;
    logic watchdog_counter_clear, watchdog_counter_run, prefetch_next, resume_exec;
    logic vector_call, device_reset_req, regulator_low_power, sleep_active;
    logic power_down_flag, timeout_flag;
    int n_errors, check_count;

    spdc_top u_dut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .sleep_exec, .int_flags, .int_enables, .global_int_enable,
        .external_reset_pin, .brownout_reset, .por_reset, .watchdog_timeout, .cpu_clk_en,
        .low_freq_internal_osc_en, .timer1_clk_en, .adc_clk_en, .io_hold,
        .watchdog_counter_clear, .watchdog_counter_run, .prefetch_next, .resume_exec,
        .vector_call, .device_reset_req, .regulator_low_power, .sleep_active,
        .power_down_flag, .timeout_flag);
    spdc_core_model u_core (.clk, .sleep_exec, .int_flags, .int_enables, .global_int_enable,
        .external_reset_pin, .brownout_reset, .por_reset, .watchdog_timeout);

    // ============================================================
    // Clock and shared tasks
    initial clk = 1'h0;
    always #25 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s: got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk

    // Request held until pready is sampled high; a dead slave ends in a mismatch
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        @(posedge clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
        chk(n < 50, 1, "apb hang");
    endtask : apb

    task automatic wrap_up();
        if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    // Set options, mark the flags, sleep and check the entry state
    task automatic enter(input logic [5:0] cfg, input logic lps);
        logic [31:0] rd;
        logic e;
        apb(1, OFF_CONFIG, {26'h0, cfg}, rd, e);
        apb(1, OFF_REGCTL, {30'h0, lps, 1'h1}, rd, e);
        apb(1, OFF_STATUS, 32'h1, rd, e);
        u_core.do_sleep();
        @(negedge clk);
        chk({sleep_active, power_down_flag, timeout_flag, cpu_clk_en, watchdog_counter_clear,
             prefetch_next, io_hold, low_freq_internal_osc_en}, 8'hAF, "entry");
        chk({timer1_clk_en, adc_clk_en, watchdog_counter_run, regulator_low_power},
            {cfg[5:4] != 2'h0, cfg[3], cfg[2], lps}, "sleep clocks");
    endtask : enter

    // ============================================================
    // Scenarios
    task automatic t_regs();
        logic [31:0] rd;
        logic e;
        @(negedge clk);
        chk({cpu_clk_en, low_freq_internal_osc_en, timer1_clk_en, adc_clk_en,
             watchdog_counter_run, power_down_flag, timeout_flag, io_hold, sleep_active,
             resume_exec, device_reset_req}, 11'h7F0, "reset outs");
        apb(0, OFF_REGCTL, 32'h0, rd, e);
        chk(rd, 32'h1, "regctl reset");
        apb(1, OFF_REGCTL, 32'h0, rd, e);
        apb(0, OFF_REGCTL, 32'h0, rd, e);
        chk(rd, 32'h1, "reserved bit");
        apb(0, OFF_STATUS, 32'h0, rd, e);
        chk(rd[1:0], 2'h3, "status reset");
        apb(0, 8'h0C, 32'h0, rd, e);
        chk(e, 1, "unmapped err");
        chk(rd, 32'h0, "unmapped data");
    endtask : t_regs

    task automatic t_noop();
        logic [31:0] rd;
        logic e;
        apb(1, OFF_STATUS, 32'h1, rd, e);
        u_core.set_int(8'h01, 8'h01, 1'h0);
        u_core.do_sleep();
        @(negedge clk);
        chk({prefetch_next, sleep_active, watchdog_counter_clear, power_down_flag,
             timeout_flag}, 5'h12, "noop sleep");
        apb(0, OFF_STATUS, 32'h0, rd, e);
        chk(rd[1:0], 2'h1, "noop flags");
        u_core.set_int(8'h00, 8'h00, 1'h0);
    endtask : t_noop

    // Interrupt wake; delay grows with crystal start-up and regulator recovery
    task automatic t_wake(input logic [5:0] cfg, input logic lps, input logic g);
        int n, extra;
        extra = ((cfg[0] && !cfg[1]) ? OST_CYCLES : 0) + (lps ? REG_CYCLES : 0);
        enter(cfg, lps);
        u_core.set_int(8'h10, 8'h20, g);
        repeat (4) @(negedge clk);
        chk(sleep_active, 1, "masked int woke");
        u_core.set_int(8'h10, 8'h10, g);
        n = 0;
        do begin
            @(negedge clk);
            n++;
            if (n == 2) chk(watchdog_counter_clear, 1, "wake clear");
        end while (resume_exec !== 1'h1 && n < 2000);
        chk(n >= extra + 1 && n <= extra + 3, 1, "wake delay");
        chk({vector_call, watchdog_counter_clear, cpu_clk_en, io_hold, sleep_active},
            {g, extra == 0, 3'h4}, "resume");
        u_core.set_int(8'h00, 8'h00, 1'h0);
    endtask : t_wake

    // Pin, brown-out and power-on reset; watchdog resumes
    task automatic t_src(input int k);
        enter(6'h00, 1'h0);
        u_core.pulse_src(k);
        @(negedge clk);
        chk({device_reset_req, resume_exec, watchdog_counter_clear},
            {k < 3, k == 3, 1'h1}, "event wake");
        repeat (3) @(negedge clk);
        chk(sleep_active, 0, "left sleep");
    endtask : t_src

    // ============================================================
    // Main sequence and watchdog
    initial begin
        {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
        n_errors = 0;
        check_count = 0;
        repeat (8) @(posedge clk);
        resetn <= 1'h1;
        t_regs();
        t_noop();
        t_wake(6'h00, 1'h0, 1'h0);
        t_wake(6'h1C, 1'h0, 1'h1);
        t_wake(6'h21, 1'h0, 1'h0);
        t_wake(6'h33, 1'h0, 1'h1);
        t_wake(6'h00, 1'h1, 1'h1);
        for (int k = 0; k < 4; k++) t_src(k);
        u_core.pulse_src(1);
        @(negedge clk);
        chk(device_reset_req, 1, "reset in run");
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        wrap_up();
    end
endmodule : tb
